// [common/acfg_consts.svh]
`ifndef ACFG_CONSTS_SVH
`define ACFG_CONSTS_SVH

// ==========================================================
// register offsets
`define ACFG_OFS_INPUT_SETUP    8'h41
`define ACFG_OFS_ANALOG_GAIN    8'h42
`define ACFG_OFS_DIGITAL_VOLUME 8'h43
`define ACFG_OFS_GAIN_TRIM      8'h44

// ==========================================================
// reset values
`define ACFG_RST_INPUT_SETUP    8'h00
`define ACFG_RST_ANALOG_GAIN    8'h00
`define ACFG_RST_DIGITAL_VOLUME 8'hC9
`define ACFG_RST_GAIN_TRIM      8'h80

// ==========================================================
// input setup fields
`define ACFG_BIT_LINE_NOT_MIC   7
`define ACFG_SRC_HI             6
`define ACFG_SRC_LO             5
`define ACFG_BIT_DIRECT_COUPLE  4
`define ACFG_IMP_HI             3
`define ACFG_IMP_LO             2
`define ACFG_BIT_SETUP_RSVD     1
`define ACFG_BIT_DYN_ENABLE     0

// writable masks, reserved bits stay zero
`define ACFG_MASK_INPUT_SETUP   8'hFD
`define ACFG_MASK_GAIN_TRIM     8'hF0

// ==========================================================
// analog gain fields
`define ACFG_GAIN_HI            7
`define ACFG_GAIN_LO            1
`define ACFG_BIT_GAIN_NEG       0
`define ACFG_GAIN_MAX_CODE      7'h54
`define ACFG_GAIN_NEG_MAX_CODE  7'h16

// ==========================================================
// volume and trim fields
`define ACFG_VOL_MUTE_CODE      8'h00
`define ACFG_VOL_UNITY_CODE     9'h0C9
`define ACFG_TRIM_HI            7
`define ACFG_TRIM_LO            4
`define ACFG_TRIM_UNITY_CODE    5'h08

`endif

// [common/acfg_pkg.sv]
package acfg_pkg;

    typedef enum logic [1:0] {
        acfg_src_analog_diff   = 2'h0,
        acfg_src_analog_single = 2'h1,
        acfg_src_pdm_mic       = 2'h2,
        acfg_src_reserved      = 2'h3
    } acfg_source_type;

    typedef enum logic [1:0] {
        acfg_imp_2k5      = 2'h0,
        acfg_imp_10k      = 2'h1,
        acfg_imp_20k      = 2'h2,
        acfg_imp_reserved = 2'h3
    } acfg_impedance_type;

endpackage : acfg_pkg

// [logic/acfg_level_map.sv]
`timescale 1ns/1ns
`include "acfg_consts.svh"

module acfg_level_map (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // raw codes
    input  wire logic [6:0]        gain_code,
    input  wire logic              gain_negative,
    input  wire logic              negative_allowed,
    input  wire logic [7:0]        volume_code,
    input  wire logic [3:0]        trim_code,
    // mapped levels
    output logic signed [7:0]      gain_half_db,
    output logic                   volume_muted,
    output logic signed [8:0]      volume_half_db,
    output logic signed [4:0]      trim_tenth_db
);

    logic [6:0] gain_clamped;

    // reserved codes clamp at the top of the range, never wrap
    always_comb begin
        if (gain_code > `ACFG_GAIN_MAX_CODE) begin
            gain_clamped = `ACFG_GAIN_MAX_CODE;
        end else begin
            gain_clamped = gain_code;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gain_half_db <= 8'sh00;
        end else if (gain_negative && negative_allowed) begin
            if (gain_clamped > `ACFG_GAIN_NEG_MAX_CODE) begin
                gain_half_db <= -$signed({1'b0, `ACFG_GAIN_NEG_MAX_CODE});
            end else begin
                gain_half_db <= -$signed({1'b0, gain_clamped});
            end
        end else begin
            gain_half_db <= $signed({1'b0, gain_clamped});
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            volume_muted   <= 1'b0;
            volume_half_db <= 9'sh000;
        end else begin
            volume_muted   <= (volume_code == `ACFG_VOL_MUTE_CODE);
            volume_half_db <= $signed({1'b0, volume_code} - `ACFG_VOL_UNITY_CODE);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trim_tenth_db <= 5'sh00;
        end else begin
            trim_tenth_db <= $signed({1'b0, trim_code} - `ACFG_TRIM_UNITY_CODE);
        end
    end

endmodule : acfg_level_map

// [logic/acfg_chan2_regs.sv]
`timescale 1ns/1ns
`include "acfg_consts.svh"

// Functional notes
// - Bit 7 of the input setup byte picks microphone (0) or line (1) input.
// - Bits 6:5 pick analog differential, analog single-ended or PDM mic; 3 is reserved.
// - Bit 4 picks AC (0) or DC (1) coupling and matters only for analog sources.
// - Bits 3:2 pick 2.5k, 10k or 20k input impedance; 3 is reserved.
// - Reserved bits read as zero and software writes only zero to them.
// - Bit 0 enables dynamics processing, the function picked by the global select bit.
// - The 7-bit gain code sets 0 dB to 42 dB over codes 0 to 84; higher codes are reserved.
// - The gain sign bit makes gain negative, down to -11 dB, only at 10k or 20k impedance.
// - Volume code 0 mutes, 1 is -100 dB, 201 is 0 dB, 255 is +27 dB, reset is 201.
// - Trim code 0 is -0.8 dB, 8 is 0 dB and the reset, 15 is +0.7 dB.

module acfg_chan2_regs (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // register port of the control interface
    input  wire logic [7:0]                reg_addr,
    input  wire logic                      reg_wr_en,
    input  wire logic [7:0]                reg_wr_data,
    input  wire logic                      reg_rd_en,
    output logic [7:0]                     reg_rd_data,
    output logic                           reg_rd_valid,
    // global dynamics function select bit
    input  wire logic                      dynamics_function_select,
    // channel settings
    output logic                           chan2_line_not_mic,
    output acfg_pkg::acfg_source_type      chan2_source_select,
    output logic                           chan2_direct_coupling,
    output acfg_pkg::acfg_impedance_type   chan2_impedance_select,
    output logic                           chan2_dynamics_enable,
    output logic [6:0]                     chan2_gain_code,
    output logic                           chan2_gain_negative,
    output logic [7:0]                     chan2_volume_code,
    output logic [3:0]                     chan2_gain_trim_code,
    // derived controls
    output logic                           analog_path_on,
    output logic                           pdm_path_on,
    output logic                           enhancer_path_on,
    output logic                           alternate_dyn_on,
    output logic                           setting_fault,
    // mapped levels
    output logic signed [7:0]              gain_half_db,
    output logic                           volume_muted,
    output logic signed [8:0]              volume_half_db,
    output logic signed [4:0]              trim_tenth_db
);

    // ==========================================================
    // helpers
    function automatic logic is_analog(input logic [1:0] src);
        is_analog = (src == acfg_pkg::acfg_src_analog_diff) ||
                    (src == acfg_pkg::acfg_src_analog_single);
    endfunction : is_analog

    function automatic logic is_hit(input logic [7:0] addr, input logic [7:0] ofs);
        is_hit = (addr == ofs);
    endfunction : is_hit

    // ==========================================================
    // storage
    logic [7:0] chan2_input_setup;
    logic [7:0] chan2_analog_gain;
    logic [7:0] chan2_digital_volume;
    logic [7:0] chan2_gain_trim;
    logic       negative_allowed;

    // reserved bits are masked on write so they can never read back set
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan2_input_setup <= `ACFG_RST_INPUT_SETUP;
        end else if (reg_wr_en && is_hit(reg_addr, `ACFG_OFS_INPUT_SETUP)) begin
            chan2_input_setup <= reg_wr_data & `ACFG_MASK_INPUT_SETUP;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan2_analog_gain <= `ACFG_RST_ANALOG_GAIN;
        end else if (reg_wr_en && is_hit(reg_addr, `ACFG_OFS_ANALOG_GAIN)) begin
            chan2_analog_gain <= reg_wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan2_digital_volume <= `ACFG_RST_DIGITAL_VOLUME;
        end else if (reg_wr_en && is_hit(reg_addr, `ACFG_OFS_DIGITAL_VOLUME)) begin
            chan2_digital_volume <= reg_wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan2_gain_trim <= `ACFG_RST_GAIN_TRIM;
        end else if (reg_wr_en && is_hit(reg_addr, `ACFG_OFS_GAIN_TRIM)) begin
            chan2_gain_trim <= reg_wr_data & `ACFG_MASK_GAIN_TRIM;
        end
    end

    // ==========================================================
    // read port: one cycle latency, unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rd_data  <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (!reg_rd_en) begin
                reg_rd_data <= 8'h00;
            end else if (is_hit(reg_addr, `ACFG_OFS_INPUT_SETUP)) begin
                reg_rd_data <= chan2_input_setup;
            end else if (is_hit(reg_addr, `ACFG_OFS_ANALOG_GAIN)) begin
                reg_rd_data <= chan2_analog_gain;
            end else if (is_hit(reg_addr, `ACFG_OFS_DIGITAL_VOLUME)) begin
                reg_rd_data <= chan2_digital_volume;
            end else if (is_hit(reg_addr, `ACFG_OFS_GAIN_TRIM)) begin
                reg_rd_data <= chan2_gain_trim;
            end else begin
                reg_rd_data <= 8'h00;
            end
        end
    end

    // ==========================================================
    // field outputs, registered copies of the stored bytes, except coupling, which is gated to analog sources
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chan2_line_not_mic     <= 1'b0;
            chan2_source_select    <= acfg_pkg::acfg_src_analog_diff;
            chan2_direct_coupling  <= 1'b0;
            chan2_impedance_select <= acfg_pkg::acfg_imp_2k5;
            chan2_dynamics_enable  <= 1'b0;
            chan2_gain_code        <= 7'h00;
            chan2_gain_negative    <= 1'b0;
            chan2_volume_code      <= `ACFG_RST_DIGITAL_VOLUME;
            chan2_gain_trim_code   <= 4'(`ACFG_RST_GAIN_TRIM >> `ACFG_TRIM_LO);
        end else begin
            chan2_line_not_mic     <= chan2_input_setup[`ACFG_BIT_LINE_NOT_MIC];
            chan2_source_select    <= acfg_pkg::acfg_source_type'(
                chan2_input_setup[`ACFG_SRC_HI:`ACFG_SRC_LO]);
            // coupling only means something on an analog input
            chan2_direct_coupling  <= chan2_input_setup[`ACFG_BIT_DIRECT_COUPLE] &
                is_analog(chan2_input_setup[`ACFG_SRC_HI:`ACFG_SRC_LO]);
            chan2_impedance_select <= acfg_pkg::acfg_impedance_type'(
                chan2_input_setup[`ACFG_IMP_HI:`ACFG_IMP_LO]);
            chan2_dynamics_enable  <= chan2_input_setup[`ACFG_BIT_DYN_ENABLE];
            chan2_gain_code        <= chan2_analog_gain[`ACFG_GAIN_HI:`ACFG_GAIN_LO];
            chan2_gain_negative    <= chan2_analog_gain[`ACFG_BIT_GAIN_NEG];
            chan2_volume_code      <= chan2_digital_volume;
            chan2_gain_trim_code   <= chan2_gain_trim[`ACFG_TRIM_HI:`ACFG_TRIM_LO];
        end
    end

    // ==========================================================
    // derived controls
    // negative gain only at 10k or 20k; elsewhere the sign bit leaves gain positive and sets setting_fault
    assign negative_allowed =
        (chan2_input_setup[`ACFG_IMP_HI:`ACFG_IMP_LO] == acfg_pkg::acfg_imp_10k) ||
        (chan2_input_setup[`ACFG_IMP_HI:`ACFG_IMP_LO] == acfg_pkg::acfg_imp_20k);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_path_on   <= 1'b0;
            pdm_path_on      <= 1'b0;
            enhancer_path_on <= 1'b0;
            alternate_dyn_on <= 1'b0;
        end else begin
            // shared pin setup is software's job before these switch
            analog_path_on   <= is_analog(chan2_input_setup[`ACFG_SRC_HI:`ACFG_SRC_LO]);
            pdm_path_on      <= (chan2_input_setup[`ACFG_SRC_HI:`ACFG_SRC_LO] ==
                                 acfg_pkg::acfg_src_pdm_mic);
            enhancer_path_on <= chan2_input_setup[`ACFG_BIT_DYN_ENABLE] &
                                ~dynamics_function_select;
            alternate_dyn_on <= chan2_input_setup[`ACFG_BIT_DYN_ENABLE] &
                                dynamics_function_select;
        end
    end

    // reserved codes are flagged, not blocked, so software can see its mistake
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            setting_fault <= 1'b0;
        end else begin
            setting_fault <=
                (chan2_input_setup[`ACFG_SRC_HI:`ACFG_SRC_LO] == acfg_pkg::acfg_src_reserved) ||
                (chan2_input_setup[`ACFG_IMP_HI:`ACFG_IMP_LO] == acfg_pkg::acfg_imp_reserved) ||
                (chan2_analog_gain[`ACFG_GAIN_HI:`ACFG_GAIN_LO] > `ACFG_GAIN_MAX_CODE) ||
                (chan2_analog_gain[`ACFG_BIT_GAIN_NEG] && !negative_allowed);
        end
    end

    // ==========================================================
    // level mapping
    acfg_level_map u_level_map (
        .mclk             (mclk),
        .rst_n            (rst_n),
        .gain_code        (chan2_analog_gain[`ACFG_GAIN_HI:`ACFG_GAIN_LO]),
        .gain_negative    (chan2_analog_gain[`ACFG_BIT_GAIN_NEG]),
        .negative_allowed (negative_allowed),
        .volume_code      (chan2_digital_volume),
        .trim_code        (chan2_gain_trim[`ACFG_TRIM_HI:`ACFG_TRIM_LO]),
        .gain_half_db     (gain_half_db),
        .volume_muted     (volume_muted),
        .volume_half_db   (volume_half_db),
        .trim_tenth_db    (trim_tenth_db)
    );

endmodule : acfg_chan2_regs

// [test/acfg_chan2_asserts.sv]
`timescale 1ns/1ns

// ==========================================================
// checker on the channel 2 register bank ports
module acfg_chan2_checker (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    rst_n,
    // register port
    input wire logic [7:0]              reg_addr,
    input wire logic                    reg_wr_en,
    input wire logic [7:0]              reg_wr_data,
    input wire logic                    reg_rd_en,
    input wire logic [7:0]              reg_rd_data,
    input wire logic                    reg_rd_valid,
    // settings and derived controls
    input wire acfg_pkg::acfg_source_type chan2_source_select,
    input wire logic                    chan2_direct_coupling,
    input wire logic                    chan2_dynamics_enable,
    input wire logic [6:0]              chan2_gain_code,
    input wire logic                    chan2_gain_negative,
    input wire logic [7:0]              chan2_volume_code,
    input wire logic [3:0]              chan2_gain_trim_code,
    input wire logic                    pdm_path_on,
    input wire logic                    enhancer_path_on,
    input wire logic                    alternate_dyn_on,
    input wire logic                    setting_fault,
    // mapped levels
    input wire logic signed [7:0]       gain_half_db,
    input wire logic                    volume_muted,
    input wire logic signed [8:0]       volume_half_db,
    input wire logic signed [4:0]       trim_tenth_db
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe not answered next cycle");
    a_idle_data_zero: assert property (!reg_rd_valid |-> reg_rd_data == 8'h00)
        else $error("read data not zero while idle");
    a_setup_rsvd_zero: assert property (
        reg_rd_en && reg_addr == 8'h41 |=> reg_rd_data[1] == 1'b0)
        else $error("setup reserved bit read nonzero");
    a_trim_rsvd_zero: assert property (
        reg_rd_en && reg_addr == 8'h44 |=> reg_rd_data[3:0] == 4'h0)
        else $error("trim reserved bits read nonzero");
    a_unmapped_zero: assert property (
        reg_rd_en && !(reg_addr inside {[8'h41:8'h44]}) |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_volume_lands: assert property (
        (reg_wr_en && reg_addr == 8'h43) ##1 !(reg_wr_en && reg_addr == 8'h43)
        |=> chan2_volume_code == $past(reg_wr_data, 2))
        else $error("volume write did not land");
    a_volume_map: assert property (
        volume_muted == (chan2_volume_code == 8'h00) &&
        volume_half_db == $signed({1'b0, chan2_volume_code}) - 9'sd201)
        else $error("volume mapping wrong");
    a_trim_map: assert property (
        trim_tenth_db == $signed({1'b0, chan2_gain_trim_code}) - 5'sd8)
        else $error("trim mapping wrong");
    a_gain_clamp: assert property (!chan2_gain_negative |->
        gain_half_db == (chan2_gain_code > 7'd84 ? 8'sd84 : $signed({1'b0, chan2_gain_code})))
        else $error("positive gain mapping wrong");
    a_pdm_path: assert property (
        pdm_path_on == (chan2_source_select == acfg_pkg::acfg_src_pdm_mic))
        else $error("pdm path flag wrong");
    a_coupling_analog: assert property (
        chan2_direct_coupling |-> chan2_source_select[1] == 1'b0)
        else $error("coupling set on non analog source");
    a_dyn_off: assert property (
        !chan2_dynamics_enable |-> !enhancer_path_on && !alternate_dyn_on)
        else $error("dynamics path on while disabled");
    a_fault_reserved: assert property (
        chan2_source_select == acfg_pkg::acfg_src_reserved || chan2_gain_code > 7'd84
        |-> setting_fault)
        else $error("reserved code not flagged");

    c_volume_write: cover property (reg_wr_en && reg_addr == 8'h43);
    c_read: cover property (reg_rd_valid);
    c_pdm: cover property (pdm_path_on);
    c_neg_gain: cover property (chan2_gain_negative && gain_half_db < 8'sd0);
endmodule : acfg_chan2_checker

bind acfg_chan2_regs acfg_chan2_checker acfg_chan2_checker_i (
    .mclk, .rst_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
    .reg_rd_valid, .chan2_source_select, .chan2_direct_coupling, .chan2_dynamics_enable,
    .chan2_gain_code, .chan2_gain_negative, .chan2_volume_code, .chan2_gain_trim_code,
    .pdm_path_on, .enhancer_path_on, .alternate_dyn_on, .setting_fault, .gain_half_db,
    .volume_muted, .volume_half_db, .trim_tenth_db);

// [test/tb_top.sv]
`timescale 1ns/1ns

// ==========================================================
// register bank bench
module tb_top;
    logic        mclk, rst_n, reg_wr_en, reg_rd_en, dynamics_function_select;
    logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, chan2_volume_code, v;
    logic        reg_rd_valid, chan2_line_not_mic, chan2_direct_coupling, chan2_dynamics_enable;
    logic        chan2_gain_negative, analog_path_on, pdm_path_on, enhancer_path_on;
    logic        alternate_dyn_on, setting_fault, volume_muted;
    logic [6:0]  chan2_gain_code, g;
    logic [3:0]  chan2_gain_trim_code;
    logic [1:0]  s;
    logic signed [7:0] gain_half_db;
    logic signed [8:0] volume_half_db;
    logic signed [4:0] trim_tenth_db;
    acfg_pkg::acfg_source_type    chan2_source_select;
    acfg_pkg::acfg_impedance_type chan2_impedance_select;
    int          errors, cmp_count, cycles;
    logic [7:0]  rst_tab [4] = '{8'h00, 8'h00, 8'hC9, 8'h80};
    logic [6:0]  g_tab [5] = '{7'h00, 7'h01, 7'h54, 7'h55, 7'h7F};
    logic [7:0]  v_tab [6] = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hCA, 8'hFF};

    acfg_chan2_regs acfg_chan2_regs_i (.mclk, .rst_n, .reg_addr, .reg_wr_en, .reg_wr_data,
        .reg_rd_en, .reg_rd_data, .reg_rd_valid, .dynamics_function_select,
        .chan2_line_not_mic, .chan2_source_select, .chan2_direct_coupling,
        .chan2_impedance_select, .chan2_dynamics_enable, .chan2_gain_code,
        .chan2_gain_negative, .chan2_volume_code, .chan2_gain_trim_code, .analog_path_on,
        .pdm_path_on, .enhancer_path_on, .alternate_dyn_on, .setting_fault, .gain_half_db,
        .volume_muted, .volume_half_db, .trim_tenth_db);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] got);
        cmp_count++;
        if (got !== e) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, got);
        end
    endtask : chk

    // outputs are settled one edge after the write is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        // the answer stands for one cycle only, look before the next edge
        #1;
        chk("rd_valid", 9'h001, {8'h00, reg_rd_valid});
        chk("rd_data", {1'b0, e}, {1'b0, reg_rd_data});
    endtask : rd

    task automatic end_sim;
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // hang guard, the whole sequence needs well under 1000 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        dynamics_function_select = 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(8'(8'h41 + i), rst_tab[i]);
        chk("volume_code", 9'h0C9, {1'b0, chan2_volume_code});
        chk("trim_code", 9'h008, {5'h00, chan2_gain_trim_code});
        // unmapped places neither store nor disturb
        wr(8'h45, 8'h5A);
        rd(8'h45, 8'h00);
        rd(8'h40, 8'h00);
        rd(8'h43, 8'hC9);
        wr(8'h41, 8'hFF);
        rd(8'h41, 8'hFD);
        chk("dyn_enable", 9'h001, {8'h00, chan2_dynamics_enable});
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            @(posedge mclk);
            dynamics_function_select <= s[0];
            wr(8'h41, {s[0], s, 1'b1, 2'b01, 1'b0, 1'b1});
            chk("line_not_mic", {8'h00, s[0]}, {8'h00, chan2_line_not_mic});
            chk("source", {7'h00, s}, {7'h00, chan2_source_select});
            chk("pdm_path", {8'h00, s == 2'h2}, {8'h00, pdm_path_on});
            chk("analog_path", {8'h00, !s[1]}, {8'h00, analog_path_on});
            chk("coupling", {8'h00, !s[1]}, {8'h00, chan2_direct_coupling});
            chk("fault", {8'h00, s == 2'h3}, {8'h00, setting_fault});
            chk("dyn_paths", {7'h00, !s[0], s[0]}, {7'h00, enhancer_path_on, alternate_dyn_on});
        end
        wr(8'h42, 8'h3D);
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            wr(8'h41, {4'h0, s, 2'b00});
            chk("impedance", {7'h00, s}, {7'h00, chan2_impedance_select});
            chk("gain_db", (s == 2'h1 || s == 2'h2) ? 9'h1EA : 9'h01E, gain_half_db);
            chk("fault", {8'h00, s == 2'h0 || s == 2'h3}, {8'h00, setting_fault});
            chk("dyn_paths", 9'h000, {7'h00, enhancer_path_on, alternate_dyn_on});
        end
        wr(8'h41, 8'h04);
        for (int i = 0; i < 5; i++) begin
            g = g_tab[i];
            wr(8'h42, {g, 1'b0});
            rd(8'h42, {g, 1'b0});
            chk("gain_code", {2'h0, g}, {2'h0, chan2_gain_code});
            chk("gain_db", {2'h0, (g > 7'h54) ? 7'h54 : g}, gain_half_db);
            chk("fault", {8'h00, g > 7'h54}, {8'h00, setting_fault});
        end
        wr(8'h42, {7'h0A, 1'b1});
        chk("gain_db", 9'h1F6, gain_half_db);
        chk("gain_negative", 9'h001, {8'h00, chan2_gain_negative});
        for (int i = 0; i < 6; i++) begin
            v = v_tab[i];
            wr(8'h43, v);
            rd(8'h43, v);
            chk("muted", {8'h00, v == 8'h00}, {8'h00, volume_muted});
            chk("volume_code", {1'b0, v}, {1'b0, chan2_volume_code});
            chk("volume_db", {1'b0, v} - 9'h0C9, volume_half_db);
        end
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'h9A;
            wr(8'h44, v);
            rd(8'h44, v & 8'hF0);
            chk("trim_db", {5'h00, v[7:4]} - 9'h008, trim_tenth_db);
            chk("trim_code", {5'h00, v[7:4]}, {5'h00, chan2_gain_trim_code});
        end
        end_sim();
    end
endmodule : tb_top
